/* core/three_wire_map.svh */
// Offsets, field positions, reset values and timing counts of the three-wire register port
`ifndef THREE_WIRE_MAP_SVH
`define THREE_WIRE_MAP_SVH
`define TW_REG_IDENT        7'h00
`define TW_REG_CVTRIM       7'h01
`define TW_REG_MODESEL      7'h02
`define TW_REG_SWRESET      7'h0A
`define TW_READ_LAST_IDX    7'h3F
`define TW_CVTRIM_RESET     8'h68
`define TW_MODESEL_RESET    8'h00
`define TW_PART_MSB         5
`define TW_PART_LSB         3
`define TW_REV_MSB          2
`define TW_REV_LSB          0
`define TW_TRIM_AMP_MSB     7
`define TW_TRIM_AMP_LSB     5
`define TW_TRIM_OFS_MSB     3
`define TW_TRIM_OFS_LSB     0
`define TW_MODE_BIT         7
`define TW_SWRESET_BIT      0
`define TW_FRAME_BITS       5'h10
`define TW_LAST_CMD_BIT     5'h07
`endif

/* core/three_wire_pkg.sv */
// Types shared by the three-wire register port
package three_wire_pkg;
    typedef enum logic [1:0]
    {
        PH_CMD   = 2'b00,
        PH_WDATA = 2'b01,
        PH_RDATA = 2'b10,
        PH_DONE  = 2'b11
    } phase_t;
endpackage

/* core/three_wire_register_port.sv */
// Three-wire serial register port of the display module
//
// Notes on behaviour
// - Frame is direction bit, address bits 6..0, data bits 7..0; sampled on rising clock.
// - Each collected byte becomes parallel on the rising edge of its eighth clock.
// - Shift register and bit counter held at initial values while select is inactive.
// - Partial byte cut by select or hardware reset is discarded; resend accepted later.
// - Direction bit high is a read; the device returns the next byte.
// - Read data changes on falling clock; host captures it on rising clock.
// - Registers at index 0 through 63 are all readable.
// - Hardware reset low or software reset command restores every register default.
// - Identification register is read-only: part code bits 5..3, revision bits 2..0.
// - Trim register defaults to 68h: amplitude bits 7..5, offset code bits 3..0.
// - Mode register bit 7 selects interface mode; zero is sync plus data-enable mode.
`timescale 1ns/1ps
`include "three_wire_map.svh"
module three_wire_register_port
#(
    parameter logic [2:0] PART_CODE = 3'h0,  // Arbitrary value, set by mask option
    parameter logic [2:0] REV_CODE  = 3'h0   // Arbitrary value, set by mask option
)
(
    // Clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       srst_i,
    // Serial pins
    input  wire logic       hw_reset_low_i,
    input  wire logic       sclk_i,
    input  wire logic       cs_n_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    // Register contents towards the display module
    output logic [2:0]      trim_amplitude_o,
    output logic [3:0]      trim_offset_o,
    output logic            interface_mode_bit_o
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] sclk_s_r;
    logic [1:0] cs_s_r;
    logic [1:0] sda_s_r;
    logic [1:0] rst_s_r;
    logic       sclk_d_r;
    logic [1:0] sclk_s_nxt;
    logic [1:0] cs_s_nxt;
    logic [1:0] sda_s_nxt;
    logic [1:0] rst_s_nxt;

    always_comb
    begin
        sclk_s_nxt = {sclk_s_r[0], sclk_i};
        cs_s_nxt   = {cs_s_r[0], cs_n_i};
        sda_s_nxt  = {sda_s_r[0], sda_i};
        rst_s_nxt  = {rst_s_r[0], hw_reset_low_i};
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            sclk_s_r <= 2'h0;
            cs_s_r   <= 2'h3;
            sda_s_r  <= 2'h0;
            rst_s_r  <= 2'h3;
            sclk_d_r <= 1'b0;
        end
        else
        begin
            sclk_s_r <= sclk_s_nxt;
            cs_s_r   <= cs_s_nxt;
            sda_s_r  <= sda_s_nxt;
            rst_s_r  <= rst_s_nxt;
            sclk_d_r <= sclk_s_r[1];
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    logic cs_act;
    logic hw_rst;
    logic sda_in;

    assign sclk_rise = sclk_s_r[1] & ~sclk_d_r;
    assign sclk_fall = ~sclk_s_r[1] & sclk_d_r;
    assign cs_act    = ~cs_s_r[1];
    assign hw_rst    = ~rst_s_r[1];
    assign sda_in    = sda_s_r[1];

    // ------------------------------------------------------------
    // Serial engine
    // ------------------------------------------------------------
    three_wire_pkg::phase_t phase_r;
    three_wire_pkg::phase_t phase_nxt;
    logic [4:0] cnt_r;
    logic [4:0] cnt_nxt;
    logic [7:0] shift_r;
    logic [7:0] shift_nxt;
    logic       rd_r;
    logic       rd_nxt;
    logic [6:0] addr_r;
    logic [6:0] addr_nxt;
    logic [7:0] out_r;
    logic [7:0] out_nxt;
    logic       oe_r;
    logic       oe_nxt;
    logic       wr_stb;
    logic [7:0] wr_byte;
    logic [7:0] rd_value;
    logic [7:0] trim_r;
    logic [7:0] trim_nxt;
    logic [7:0] mode_r;
    logic [7:0] mode_nxt;
    logic [6:0] cmd_addr;

    // Address as it completes on the eighth edge; kept apart from addr_nxt to avoid a loop
    assign cmd_addr = {shift_r[5:0], sda_in};

    // Readback map; unmapped indices within the readable range return zero
    always_comb
    begin
        rd_value = 8'h00;
        case (cmd_addr)
            `TW_REG_IDENT:   rd_value = {2'h0, PART_CODE, REV_CODE};
            `TW_REG_CVTRIM:  rd_value = trim_r;
            `TW_REG_MODESEL: rd_value = mode_r;
            default:         rd_value = 8'h00;
        endcase
        if (cmd_addr > `TW_READ_LAST_IDX)
        begin
            rd_value = 8'h00;
        end
    end

    always_comb
    begin
        phase_nxt = phase_r;
        cnt_nxt   = cnt_r;
        shift_nxt = shift_r;
        rd_nxt    = rd_r;
        addr_nxt  = addr_r;
        out_nxt   = out_r;
        oe_nxt    = oe_r;
        wr_stb    = 1'b0;
        wr_byte   = 8'h00;
        if (!cs_act || hw_rst)
        begin
            // Partial bits are dropped so the host can simply resend
            phase_nxt = three_wire_pkg::PH_CMD;
            cnt_nxt   = 5'h00;
            shift_nxt = 8'h00;
            oe_nxt    = 1'b0;
        end
        else if (sclk_rise && phase_r != three_wire_pkg::PH_DONE
                 && phase_r != three_wire_pkg::PH_RDATA)
        begin
            shift_nxt = {shift_r[6:0], sda_in};
            cnt_nxt   = 5'(cnt_r + 5'h01);
            if (cnt_r == `TW_LAST_CMD_BIT)
            begin
                // Command byte goes parallel on the eighth rising edge
                rd_nxt   = shift_r[6];
                addr_nxt = cmd_addr;
                if (shift_r[6])
                begin
                    phase_nxt = three_wire_pkg::PH_RDATA;
                    out_nxt   = rd_value;
                end
                else
                begin
                    phase_nxt = three_wire_pkg::PH_WDATA;
                end
            end
            else if (cnt_r == 5'(`TW_FRAME_BITS - 5'h01))
            begin
                wr_stb    = 1'b1;
                wr_byte   = {shift_r[6:0], sda_in};
                phase_nxt = three_wire_pkg::PH_DONE;
            end
        end
        else if (phase_r == three_wire_pkg::PH_RDATA)
        begin
            // Host has released the line by now, so drive only after a falling edge
            if (sclk_fall)
            begin
                if (oe_r)
                begin
                    out_nxt = {out_r[6:0], 1'b0};
                    cnt_nxt = 5'(cnt_r + 5'h01);
                end
                oe_nxt = 1'b1;
            end
            if (sclk_rise && oe_r && cnt_r == 5'(`TW_FRAME_BITS - 5'h01))
            begin
                phase_nxt = three_wire_pkg::PH_DONE;
            end
        end
        else if (phase_r == three_wire_pkg::PH_DONE && sclk_fall)
        begin
            oe_nxt = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic swreset;

    always_comb
    begin
        swreset  = 1'b0;
        trim_nxt = trim_r;
        mode_nxt = mode_r;
        if (wr_stb)
        begin
            case (addr_r)
                `TW_REG_CVTRIM:  trim_nxt = wr_byte;
                `TW_REG_MODESEL: mode_nxt = wr_byte;
                `TW_REG_SWRESET: swreset  = wr_byte[`TW_SWRESET_BIT];
                default:         trim_nxt = trim_r;
            endcase
        end
        if (hw_rst || swreset)
        begin
            trim_nxt = `TW_CVTRIM_RESET;
            mode_nxt = `TW_MODESEL_RESET;
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            phase_r <= three_wire_pkg::PH_CMD;
            cnt_r   <= 5'h00;
            shift_r <= 8'h00;
            rd_r    <= 1'b0;
            addr_r  <= 7'h00;
            out_r   <= 8'h00;
            oe_r    <= 1'b0;
            trim_r  <= `TW_CVTRIM_RESET;
            mode_r  <= `TW_MODESEL_RESET;
        end
        else
        begin
            phase_r <= phase_nxt;
            cnt_r   <= cnt_nxt;
            shift_r <= shift_nxt;
            rd_r    <= rd_nxt;
            addr_r  <= addr_nxt;
            out_r   <= out_nxt;
            oe_r    <= oe_nxt;
            trim_r  <= trim_nxt;
            mode_r  <= mode_nxt;
        end
    end

    assign sda_o                = out_r[7];
    assign sda_oe_o             = oe_r;
    assign trim_amplitude_o     = trim_r[`TW_TRIM_AMP_MSB:`TW_TRIM_AMP_LSB];
    assign trim_offset_o        = trim_r[`TW_TRIM_OFS_MSB:`TW_TRIM_OFS_LSB];
    assign interface_mode_bit_o = mode_r[`TW_MODE_BIT];

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_idle_clear;
        @(posedge ref_clk_i) disable iff (srst_i)
        !cs_act |=> (cnt_r == 5'h00 && shift_r == 8'h00);
    endproperty
    a_idle_clear: assert property (p_idle_clear) else $error("Idle state not cleared");

    property p_no_drive_idle;
        @(posedge ref_clk_i) disable iff (srst_i)
        (!cs_act || hw_rst) |=> !sda_oe_o;
    endproperty
    a_no_drive_idle: assert property (p_no_drive_idle) else $error("Driving while idle");

    property p_hwrst_defaults;
        @(posedge ref_clk_i) disable iff (srst_i)
        hw_rst |=> (trim_r == `TW_CVTRIM_RESET && mode_r == `TW_MODESEL_RESET);
    endproperty
    a_hwrst_defaults: assert property (p_hwrst_defaults) else $error("Defaults lost");

    property p_oe_only_read;
        @(posedge ref_clk_i) disable iff (srst_i)
        $rose(sda_oe_o) |-> (rd_r && $past(sclk_fall));
    endproperty
    a_oe_only_read: assert property (p_oe_only_read) else $error("Drive outside read");

    property p_out_changes_fall;
        @(posedge ref_clk_i) disable iff (srst_i)
        (sda_oe_o && $past(sda_oe_o) && $changed(sda_o)) |-> $past(sclk_fall);
    endproperty
    a_out_changes_fall: assert property (p_out_changes_fall) else $error("Bad edge");

    property p_write_trim;
        @(posedge ref_clk_i) disable iff (srst_i)
        (wr_stb && addr_r == `TW_REG_CVTRIM && !hw_rst) |=> trim_r == $past(wr_byte);
    endproperty
    a_write_trim: assert property (p_write_trim) else $error("Trim not written");

    property p_write_mode;
        @(posedge ref_clk_i) disable iff (srst_i)
        (wr_stb && addr_r == `TW_REG_MODESEL && !hw_rst) |=> mode_r == $past(wr_byte);
    endproperty
    a_write_mode: assert property (p_write_mode) else $error("Mode not written");

    property p_ident_write;
        @(posedge ref_clk_i) disable iff (srst_i)
        (wr_stb && addr_r == `TW_REG_IDENT) |=> $stable(trim_r) && $stable(mode_r);
    endproperty
    a_ident_write: assert property (p_ident_write) else $error("Ident write leaked");

    c_write: cover property (@(posedge ref_clk_i) disable iff (srst_i) wr_stb);
    c_read: cover property (@(posedge ref_clk_i) disable iff (srst_i) $rose(sda_oe_o));
    c_abort: cover property (@(posedge ref_clk_i) disable iff (srst_i)
        (cnt_r != 5'h00) ##1 !cs_act);
endmodule

/* sim/serial_host_model.sv */
// Behavioural host microcontroller on the three-wire serial bus
`timescale 1ns/1ps
module serial_host_model
(
    // Serial pins
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      sda_o,
    input  wire logic sda_i
);
    initial
    begin
        sclk_o = 1'b1;
        cs_n_o = 1'b1;
        sda_o  = 1'b0;
    end
    // ----------------------------------------
    // Frame of nbits bits; clock idles high
    // ----------------------------------------
    // A short nbits cuts the frame before bit 0 to exercise the abort path
    task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] d,
                        input int nbits, output logic [7:0] q);
        logic [15:0] frm;
        frm = {rd, a, d};
        q = 8'h00;
        cs_n_o = 1'b0;
        #60;
        for (int i = 15; i > 15 - nbits; i--)
        begin
            sclk_o = 1'b0;
            if (i > 7 || !rd)
                sda_o = frm[i];
            #62.5 sclk_o = 1'b1;
            if (i < 8 && rd)
                q = {q[6:0], sda_i};
            // Held briefly past the last command edge so the synchroniser sees it
            #30 sda_o = (rd && i == 8) ? ~sda_o : sda_o;
            #32.5;
        end
        #60 cs_n_o = 1'b1;
        sda_o = ~sda_o;
        #1000;
    endtask
endmodule

/* sim/tb.sv */
// Self-checking bench for the three-wire register port
`timescale 1ns/1ps
`include "three_wire_map.svh"
module tb;
    localparam logic [2:0] PART = 3'h5;  // Arbitrary value
    localparam logic [2:0] REV  = 3'h2;  // Arbitrary value
    logic       ref_clk_i      = 1'b0;
    logic       srst_i         = 1'b1;
    logic       hw_reset_low_i = 1'b1;
    logic       sclk;
    logic       cs_n;
    logic       host_sda;
    logic       sda_wire;
    logic       sda_o;
    logic       sda_oe_o;
    logic       mode;
    logic [2:0] amp;
    logic [3:0] ofs;
    logic [7:0] q;
    int         failures    = 0;
    int         checks_done = 0;

    always #5 ref_clk_i = ~ref_clk_i;
    assign sda_wire = sda_oe_o ? sda_o : host_sda;

    serial_host_model serial_host_model_i
    (
        .sclk_o (sclk),
        .cs_n_o (cs_n),
        .sda_o  (host_sda),
        .sda_i  (sda_wire)
    );
    three_wire_register_port #(.PART_CODE(PART), .REV_CODE(REV)) three_wire_register_port_i
    (
        .ref_clk_i            (ref_clk_i),
        .srst_i               (srst_i),
        .hw_reset_low_i       (hw_reset_low_i),
        .sclk_i               (sclk),
        .cs_n_i               (cs_n),
        .sda_i                (sda_wire),
        .sda_o                (sda_o),
        .sda_oe_o             (sda_oe_o),
        .trim_amplitude_o     (amp),
        .trim_offset_o        (ofs),
        .interface_mode_bit_o (mode)
    );
    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d, input int n = 16);
        serial_host_model_i.xfer(1'b0, a, d, n, q);
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        serial_host_model_i.xfer(1'b1, a, 8'h00, 16, q);
        chk(q, exp);
        chk({7'h00, sda_oe_o}, 8'h00);
    endtask
    // Bit 4 of the trim register has no output, so it is masked off
    task automatic outs(input logic [7:0] t, input logic m);
        chk({amp, 1'b0, ofs}, t & 8'hEF);
        chk({7'h00, mode}, {7'h00, m});
    endtask
    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial
    begin
        #500000;
        failures++;
        $display("[ERR] %0t run did not finish", $time);
        complete_run();
    end
    initial
    begin
        repeat (16) @(negedge ref_clk_i);
        srst_i = 1'b0;
        repeat (8) @(negedge ref_clk_i);
        outs(`TW_CVTRIM_RESET, 1'b0);
        rd(`TW_REG_IDENT, {2'b00, PART, REV});
        rd(`TW_REG_CVTRIM, `TW_CVTRIM_RESET);
        rd(`TW_REG_MODESEL, `TW_MODESEL_RESET);
        $display("Test defaults done");
        wr(`TW_REG_CVTRIM, 8'hA5);
        wr(`TW_REG_MODESEL, 8'h80);
        outs(8'hA5, 1'b1);
        rd(`TW_REG_CVTRIM, 8'hA5);
        wr(`TW_REG_IDENT, 8'hFF);
        rd(`TW_REG_IDENT, {2'b00, PART, REV});
        rd(`TW_READ_LAST_IDX, 8'h00);
        rd(7'h40, 8'h00);
        $display("Test write done");
        wr(`TW_REG_CVTRIM, 8'h13, 15);
        outs(8'hA5, 1'b1);
        wr(`TW_REG_CVTRIM, 8'h13);
        outs(8'h13, 1'b1);
        fork
            wr(`TW_REG_CVTRIM, 8'h55);
            begin
                repeat (100) @(negedge ref_clk_i);
                hw_reset_low_i = 1'b0;
                repeat (110) @(negedge ref_clk_i);
                hw_reset_low_i = 1'b1;
            end
        join
        outs(`TW_CVTRIM_RESET, 1'b0);
        wr(`TW_REG_CVTRIM, 8'h55);
        outs(8'h55, 1'b0);
        $display("Test abort done");
        wr(`TW_REG_MODESEL, 8'h80);
        wr(`TW_REG_SWRESET, 8'h01);
        outs(`TW_CVTRIM_RESET, 1'b0);
        rd(`TW_REG_CVTRIM, `TW_CVTRIM_RESET);
        $display("Test software reset done");
        complete_run();
    end
endmodule
